// File: rtl/nirsc_integ_timer.sv
`timescale 1ns/1ps
`default_nettype none
module nirsc_integ_timer
	import nirsc_pkg::*;
#(
	parameter int TINT_0 = NIRSC_TINT_0_CYC,
	parameter int TINT_1 = NIRSC_TINT_1_CYC,
	parameter int TINT_2 = NIRSC_TINT_2_CYC,
	parameter int TINT_3 = NIRSC_TINT_3_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	input wire logic [1:0] time_code,
	input wire logic manual,
	input wire logic [15:0] manual_count,
	output logic done
);
	logic [31:0] base_q;
	logic [31:0] units_q;
	logic busy_q;

	function automatic logic [31:0] base_cycles(input logic [1:0] code);
		case (code)
			2'h0: base_cycles = 32'(TINT_0);
			2'h1: base_cycles = 32'(TINT_1);
			2'h2: base_cycles = 32'(TINT_2);
			default: base_cycles = 32'(TINT_3);
		endcase
	endfunction : base_cycles

	// manual mode: base time repeated manual_count times (zero treated as one)
	always_ff @(posedge clock) begin
		if (rst || abort) begin
			base_q <= 32'h0;
			units_q <= 32'h0;
			busy_q <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy_q <= 1'b1;
				base_q <= base_cycles(time_code);
				units_q <= (manual && manual_count != 16'h0000) ? {16'h0000, manual_count} : 32'h1;
			end else if (busy_q) begin
				if (base_q > 32'h1) begin
					base_q <= base_q - 32'h1;
				end else if (units_q > 32'h1) begin
					units_q <= units_q - 32'h1;
					base_q <= base_cycles(time_code);
				end else begin
					busy_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : nirsc_integ_timer
`default_nettype wire

// File: rtl/nirsc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nirsc_pin_sync (
	input wire logic clock,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// s1 only feeds s2; change taken once s2 and s3 agree
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level <= 1'b1;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level <= s3_q;
			end
		end
	end
endmodule : nirsc_pin_sync
`default_nettype wire

// File: rtl/nirsc_pkg.sv
package nirsc_pkg;

	localparam logic [6:0] NIRSC_DEV_ADDR = 7'h2A;

	localparam logic [7:0] NIRSC_REG_CTRL = 8'h00;
	localparam logic [7:0] NIRSC_REG_MAN_HI = 8'h01;
	localparam logic [7:0] NIRSC_REG_MAN_LO = 8'h02;
	localparam logic [7:0] NIRSC_REG_DATA_HI = 8'h03;
	localparam logic [7:0] NIRSC_REG_DATA_LO = 8'h04;
	localparam logic [7:0] NIRSC_REG_CLR_LAST = 8'h0A;
	localparam logic [7:0] NIRSC_REG_LED_ONE = 8'h0E;
	localparam logic [7:0] NIRSC_REG_LED_TWO = 8'h0F;

	localparam int NIRSC_CTRL_RESET_BIT = 7;
	localparam int NIRSC_CTRL_STBY_BIT = 6;
	localparam int NIRSC_CTRL_MON_BIT = 5;
	localparam int NIRSC_CTRL_CLR_BIT = 4;
	localparam int NIRSC_CTRL_GAIN_BIT = 3;
	localparam int NIRSC_CTRL_MODE_BIT = 2;
	localparam int NIRSC_CTRL_TIME_HI = 1;
	localparam int NIRSC_LED_RESET_BIT = 7;
	localparam int NIRSC_LED_STBY_BIT = 6;
	localparam int NIRSC_LED_DC_BIT = 5;
	localparam int NIRSC_LED_TENTH_BIT = 4;

	localparam logic [7:0] NIRSC_CTRL_RESET_VAL = 8'hD4;
	localparam logic [7:0] NIRSC_LED_ONE_RESET_VAL = 8'hC0;
	localparam logic [7:0] NIRSC_LED_TWO_RESET_VAL = 8'h00;
	localparam logic [15:0] NIRSC_MAN_RESET_VAL = 16'h0000;

	localparam int NIRSC_CLK_HZ = 10000000;
	localparam int NIRSC_TINT_0_NS = 32000;
	localparam int NIRSC_TINT_1_NS = 500000;
	localparam int NIRSC_TINT_2_NS = 8200000;
	localparam int NIRSC_TINT_3_NS = 65500000;
	localparam int NIRSC_CLK_NS = 1000000000 / NIRSC_CLK_HZ;
	localparam int NIRSC_TINT_0_CYC = NIRSC_TINT_0_NS / NIRSC_CLK_NS;
	localparam int NIRSC_TINT_1_CYC = NIRSC_TINT_1_NS / NIRSC_CLK_NS;
	localparam int NIRSC_TINT_2_CYC = NIRSC_TINT_2_NS / NIRSC_CLK_NS;
	localparam int NIRSC_TINT_3_CYC = NIRSC_TINT_3_NS / NIRSC_CLK_NS;

	localparam logic [6:0] NIRSC_MA_W3 = 7'd64;
	localparam logic [6:0] NIRSC_MA_W2 = 7'd32;
	localparam logic [6:0] NIRSC_MA_W1 = 7'd16;
	localparam logic [6:0] NIRSC_MA_W0 = 7'd8;

	typedef enum logic [6:0] {
		NIRSC_I_IDLE = 7'b0000001,
		NIRSC_I_ADDR = 7'b0000010,
		NIRSC_I_AACK = 7'b0000100,
		NIRSC_I_WBYTE = 7'b0001000,
		NIRSC_I_WACK = 7'b0010000,
		NIRSC_I_RBYTE = 7'b0100000,
		NIRSC_I_RACK = 7'b1000000
	} nirsc_i2c_t;

	typedef enum logic [2:0] {
		NIRSC_M_HALT = 3'b001,
		NIRSC_M_INTEG = 3'b010,
		NIRSC_M_DONE = 3'b100
	} nirsc_meas_t;

endpackage : nirsc_pkg

// File: rtl/nirsc_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - control fields: reset,standby,monitor,clear,gain,mode,time
// - reset bit holds converter; standby bit idles
// - standby monitor bit is read-only
// - clear bit zeroes data at 03..0A
// - gain bit: 0 high, 1 low
// - mode bit: 0 fixed, 1 manual count
// - time code selects 32us/0.5/8.2/65.5ms
// - led reg one: reset,standby,dc,tenth bits
// - dc bit selects drive; tenth bit only drives led_tenth, emitter ma not divided
// - drive current is sum of set weights
// - led reg one low nibble: second emitter
// - led reg two: first high, third low
// - pointer 05 read gives MSB then LSB
// - fixed mode measures continuously after release
// - start on reset fall; manual then standby
module nirsc_top
	import nirsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [15:0] adc_sample,
	output logic conv_reset,
	output logic conv_standby,
	output logic conv_low_gain,
	output logic conv_integrating,
	output logic led_reset,
	output logic led_standby,
	output logic led_dc_mode,
	output logic led_tenth,
	output logic [6:0] first_emitter_ma,
	output logic [6:0] second_emitter_ma,
	output logic [6:0] third_emitter_ma
);
	////////////////////////////////////////////////////////////////
	logic scl_s;
	logic sda_s;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	nirsc_pin_sync u_scl_sync (
		.clock(clock),
		.rst(rst),
		.pin(scl_in),
		.level(scl_s)
	);
	nirsc_pin_sync u_sda_sync (
		.clock(clock),
		.rst(rst),
		.pin(sda_in),
		.level(sda_s)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_prev_q;
	assign scl_fall = !scl_s && scl_prev_q;
	assign start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;

	////////////////////////////////////////////////////////////////
	nirsc_i2c_t st_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic ptr_set_q;
	logic [7:0] tx_q;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] rx_byte;

	assign rx_byte = {shift_q[6:0], sda_s};
	assign wr_stb = (st_q == NIRSC_I_WBYTE) && scl_rise && (bit_q == 3'h7) && ptr_set_q;
	assign wr_addr = ptr_q;
	assign wr_data = rx_byte;

	// byte shifter; ack is driven on the falling edge after bit 8
	always_ff @(posedge clock) begin
		if (rst || stop_cond) begin
			st_q <= NIRSC_I_IDLE;
			bit_q <= 3'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			ptr_set_q <= 1'b0;
			tx_q <= 8'h00;
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			st_q <= NIRSC_I_ADDR;
			bit_q <= 3'h0;
			ptr_set_q <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			case (st_q)
				NIRSC_I_IDLE: begin
					sda_oe <= 1'b0;
				end
				NIRSC_I_ADDR: begin
					if (scl_rise) begin
						shift_q <= rx_byte;
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							st_q <= (rx_byte[7:1] == NIRSC_DEV_ADDR) ? NIRSC_I_AACK : NIRSC_I_IDLE;
						end
					end
				end
				NIRSC_I_AACK: begin
					if (scl_fall && !sda_oe) begin
						sda_oe <= 1'b1;
						sda_out <= 1'b0;
					end else if (scl_fall && sda_oe) begin
						if (shift_q[0]) begin
							st_q <= NIRSC_I_RBYTE;
							tx_q <= {rd_data[6:0], 1'b0};
							sda_out <= rd_data[7];
							ptr_q <= ptr_q + 8'h01;
						end else begin
							st_q <= NIRSC_I_WBYTE;
							sda_oe <= 1'b0;
						end
					end
				end
				NIRSC_I_WBYTE: begin
					if (scl_rise) begin
						shift_q <= rx_byte;
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							st_q <= NIRSC_I_WACK;
							if (!ptr_set_q) begin
								ptr_q <= rx_byte;
								ptr_set_q <= 1'b1;
							end else begin
								ptr_q <= ptr_q + 8'h01;
							end
						end
					end
				end
				NIRSC_I_WACK: begin
					if (scl_fall && !sda_oe) begin
						sda_oe <= 1'b1;
						sda_out <= 1'b0;
					end else if (scl_fall && sda_oe) begin
						sda_oe <= 1'b0;
						st_q <= NIRSC_I_WBYTE;
					end
				end
				NIRSC_I_RBYTE: begin
					if (scl_fall) begin
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							sda_oe <= 1'b0;
							st_q <= NIRSC_I_RACK;
						end else begin
							sda_out <= tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				end
				NIRSC_I_RACK: begin
					if (scl_rise && sda_s) begin
						// host nack ends the read
						st_q <= NIRSC_I_IDLE;
					end else if (scl_fall) begin
						// host acked: next byte goes out msb first from this fall
						st_q <= NIRSC_I_RBYTE;
						tx_q <= {rd_data[6:0], 1'b0};
						sda_out <= rd_data[7];
						sda_oe <= 1'b1;
						ptr_q <= ptr_q + 8'h01;
					end
				end
				default: begin
					st_q <= NIRSC_I_IDLE;
				end
			endcase
			if (st_q == NIRSC_I_RBYTE && scl_fall && bit_q == 3'h7) begin
				sda_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_q;
	logic [7:0] led_one_q;
	logic [7:0] led_two_q;
	logic [15:0] manual_q;
	logic [15:0] result_q;
	logic monitor_q;
	logic meas_done;

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= NIRSC_CTRL_RESET_VAL;
			led_one_q <= NIRSC_LED_ONE_RESET_VAL;
			led_two_q <= NIRSC_LED_TWO_RESET_VAL;
			manual_q <= NIRSC_MAN_RESET_VAL;
		end else if (wr_stb) begin
			case (wr_addr)
				NIRSC_REG_CTRL: ctrl_q <= {wr_data[7:6], 1'b0, wr_data[4:0]};
				NIRSC_REG_MAN_HI: manual_q[15:8] <= wr_data;
				NIRSC_REG_MAN_LO: manual_q[7:0] <= wr_data;
				NIRSC_REG_LED_ONE: led_one_q <= wr_data;
				NIRSC_REG_LED_TWO: led_two_q <= wr_data;
				default: ;
			endcase
		end
		// hardware standby set wins over a write in the same cycle
		if (!rst && meas_done && ctrl_q[NIRSC_CTRL_MODE_BIT]) begin
			ctrl_q[NIRSC_CTRL_STBY_BIT] <= 1'b1;
		end
	end

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			NIRSC_REG_CTRL: reg_read = {ctrl_q[7:6], monitor_q, ctrl_q[4:0]};
			NIRSC_REG_MAN_HI: reg_read = manual_q[15:8];
			NIRSC_REG_MAN_LO: reg_read = manual_q[7:0];
			NIRSC_REG_DATA_HI: reg_read = result_q[15:8];
			NIRSC_REG_DATA_LO: reg_read = result_q[7:0];
			NIRSC_REG_LED_ONE: reg_read = led_one_q;
			NIRSC_REG_LED_TWO: reg_read = led_two_q;
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// pointer 05 aliases onto the result pair so the documented read returns msb first
	assign rd_data = (ptr_q == 8'h05) ? result_q[15:8] :
		(ptr_q == 8'h06) ? result_q[7:0] : reg_read(ptr_q);

	////////////////////////////////////////////////////////////////
	nirsc_meas_t ms_q;
	logic reset_prev_q;
	logic meas_start;
	logic meas_stop;

	assign meas_stop = ctrl_q[NIRSC_CTRL_RESET_BIT] || ctrl_q[NIRSC_CTRL_STBY_BIT];
	assign meas_start = reset_prev_q && !ctrl_q[NIRSC_CTRL_RESET_BIT] && !ctrl_q[NIRSC_CTRL_STBY_BIT];

	nirsc_integ_timer u_timer (
		.clock(clock),
		.rst(rst),
		.start(meas_start || (ms_q == NIRSC_M_DONE && !meas_stop && !ctrl_q[NIRSC_CTRL_MODE_BIT])),
		.abort(meas_stop),
		.time_code(ctrl_q[NIRSC_CTRL_TIME_HI:0]),
		.manual(ctrl_q[NIRSC_CTRL_MODE_BIT]),
		.manual_count(manual_q),
		.done(meas_done)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			ms_q <= NIRSC_M_HALT;
			reset_prev_q <= 1'b1;
			monitor_q <= 1'b1;
		end else begin
			reset_prev_q <= ctrl_q[NIRSC_CTRL_RESET_BIT];
			monitor_q <= meas_stop;
			case (ms_q)
				NIRSC_M_HALT: if (meas_start) ms_q <= NIRSC_M_INTEG;
				NIRSC_M_INTEG: begin
					if (meas_stop) ms_q <= NIRSC_M_HALT;
					else if (meas_done) ms_q <= NIRSC_M_DONE;
				end
				NIRSC_M_DONE: begin
					// fixed mode loops straight into the next integration
					ms_q <= (meas_stop || ctrl_q[NIRSC_CTRL_MODE_BIT]) ? NIRSC_M_HALT : NIRSC_M_INTEG;
				end
				default: ms_q <= NIRSC_M_HALT;
			endcase
		end
	end

	// clear wins over a completing result
	always_ff @(posedge clock) begin
		if (rst || ctrl_q[NIRSC_CTRL_CLR_BIT]) begin
			result_q <= 16'h0000;
		end else if (meas_done) begin
			result_q <= adc_sample;
		end
	end

	////////////////////////////////////////////////////////////////
	function automatic logic [6:0] drive_ma(input logic [3:0] f);
		drive_ma = (f[3] ? NIRSC_MA_W3 : 7'd0) + (f[2] ? NIRSC_MA_W2 : 7'd0)
			+ (f[1] ? NIRSC_MA_W1 : 7'd0) + (f[0] ? NIRSC_MA_W0 : 7'd0);
	endfunction : drive_ma

	always_ff @(posedge clock) begin
		if (rst) begin
			conv_reset <= 1'b1;
			conv_standby <= 1'b1;
			conv_low_gain <= 1'b0;
			conv_integrating <= 1'b0;
			led_reset <= 1'b1;
			led_standby <= 1'b1;
			led_dc_mode <= 1'b0;
			led_tenth <= 1'b0;
			first_emitter_ma <= 7'd0;
			second_emitter_ma <= 7'd0;
			third_emitter_ma <= 7'd0;
		end else begin
			conv_reset <= ctrl_q[NIRSC_CTRL_RESET_BIT];
			conv_standby <= ctrl_q[NIRSC_CTRL_STBY_BIT];
			conv_low_gain <= ctrl_q[NIRSC_CTRL_GAIN_BIT];
			conv_integrating <= (ms_q == NIRSC_M_INTEG);
			led_reset <= led_one_q[NIRSC_LED_RESET_BIT];
			led_standby <= led_one_q[NIRSC_LED_STBY_BIT];
			led_dc_mode <= led_one_q[NIRSC_LED_DC_BIT];
			led_tenth <= led_one_q[NIRSC_LED_TENTH_BIT];
			first_emitter_ma <= drive_ma(led_two_q[7:4]);
			second_emitter_ma <= drive_ma(led_one_q[3:0]);
			third_emitter_ma <= drive_ma(led_two_q[3:0]);
		end
	end
endmodule : nirsc_top
`default_nettype wire

// File: test/nirsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nirsc_host_model
	import nirsc_pkg::*;
(
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	localparam int HALF = 12;
	logic [6:0] addr = NIRSC_DEV_ADDR;
	logic nack = 1'b0;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	// sda moves 3 clocks after scl falls, never together with it
	task automatic bitx(input logic b, output logic r);
		sda_drv = b;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		r = sda;
		scl = 1'b0;
		tick(3);
	endtask : bitx
	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(ack, r);
		nack = r;
	endtask : xfer
	task automatic start();
		sda_drv = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_drv = 1'b0;
		tick(HALF);
		scl = 1'b0;
		tick(3);
	endtask : start
	task automatic stop();
		sda_drv = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_drv = 1'b1;
		tick(HALF);
	endtask : stop
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({addr, 1'b0}, 1'b1, q);
		xfer(ptr, 1'b1, q);
		xfer(d, 1'b1, q);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] ptr, output logic [15:0] v);
		logic [7:0] q;
		start();
		xfer({addr, 1'b0}, 1'b1, q);
		xfer(ptr, 1'b1, q);
		start();
		xfer({addr, 1'b1}, 1'b1, q);
		xfer(8'hFF, 1'b0, v[15:8]);
		xfer(8'hFF, 1'b1, v[7:0]);
		stop();
	endtask : rd
endmodule : nirsc_host_model
`default_nettype wire

// File: test/nirsc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module nirsc_top_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic conv_reset,
	input wire logic conv_standby,
	input wire logic conv_low_gain,
	input wire logic conv_integrating,
	input wire logic led_reset,
	input wire logic led_dc_mode,
	input wire logic led_tenth,
	input wire logic [6:0] first_emitter_ma,
	input wire logic [6:0] third_emitter_ma
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	wire logic [17:0] cfg = {conv_low_gain, led_reset, led_dc_mode, led_tenth, first_emitter_ma, third_emitter_ma};
	////////////////////////////////////////
	sequence s_release;
		$fell(conv_reset) && !conv_standby;
	endsequence
	sequence s_integ_soon;
		##[0:4] conv_integrating;
	endsequence
	property p_reset_state;
		$fell(rst) |-> conv_reset && conv_standby && led_reset && !conv_low_gain;
	endproperty
	property p_weights;
		(first_emitter_ma[2:0] == 3'h0) && (third_emitter_ma[2:0] == 3'h0);
	endproperty
	property p_hold_reset;
		conv_reset[*3] |-> !conv_integrating;
	endproperty
	property p_hold_standby;
		conv_standby[*3] |-> !conv_integrating;
	endproperty
	property p_start;
		s_release |-> s_integ_soon;
	endproperty
	property p_repeat;
		$fell(conv_integrating) && !conv_reset && !conv_standby |-> ##[1:8] (conv_integrating || conv_standby || conv_reset);
	endproperty
	// register copies move only on a data bit, seen while scl is high
	property p_cfg_on_scl;
		$changed(cfg) |-> scl_in;
	endproperty
	// sda moving under high scl would fake a start or stop
	property p_sda_steady;
		scl_in && $past(scl_in) |-> $stable(sda_oe && !sda_out);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("outputs not at reset state");
	a_weights: assert property (p_weights) else $error("current not a sum of weights");
	a_hold_reset: assert property (p_hold_reset) else $error("integrating while held");
	a_hold_standby: assert property (p_hold_standby) else $error("integrating in standby");
	a_start: assert property (p_start) else $error("no integration after release");
	a_repeat: assert property (p_repeat) else $error("fixed mode did not repeat");
	a_cfg_on_scl: assert property (p_cfg_on_scl) else $error("control copy changed off a write");
	a_sda_steady: assert property (p_sda_steady) else $error("sda moved with scl high");
endmodule : nirsc_top_checker
bind nirsc_top nirsc_top_checker chk_u (.clock(clock), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .conv_reset(conv_reset), .conv_standby(conv_standby), .conv_low_gain(conv_low_gain),
	.conv_integrating(conv_integrating), .led_reset(led_reset), .led_dc_mode(led_dc_mode),
	.led_tenth(led_tenth), .first_emitter_ma(first_emitter_ma), .third_emitter_ma(third_emitter_ma));
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import nirsc_pkg::*;
	logic clock, rst, scl, host_sda, sda_out, sda_oe;
	logic conv_reset, conv_standby, conv_low_gain, conv_integrating;
	logic led_reset, led_standby, led_dc_mode, led_tenth;
	logic [6:0] e1, e2, e3;
	logic [15:0] adc, v, ev;
	logic [7:0] d1, d2;
	wire logic sda;
	int errors = 0, samples_checked = 0, seed = 54447, run_len = 0, last_len = 0, t;
	assign sda = host_sda && !(sda_oe && !sda_out);
	nirsc_host_model host_u (.clock(clock), .sda(sda), .scl(scl), .sda_drv(host_sda));
	nirsc_top dut_u (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.adc_sample(adc), .conv_reset(conv_reset), .conv_standby(conv_standby), .conv_low_gain(conv_low_gain),
		.conv_integrating(conv_integrating), .led_reset(led_reset), .led_standby(led_standby),
		.led_dc_mode(led_dc_mode), .led_tenth(led_tenth), .first_emitter_ma(e1), .second_emitter_ma(e2),
		.third_emitter_ma(e3));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// length of the last finished integration, in clocks
	always @(posedge clock) begin
		if (conv_integrating === 1'b1) begin
			run_len++;
		end else if (run_len != 0) begin
			last_len = run_len;
			run_len = 0;
		end
	end
	function automatic logic [6:0] ma(input logic [3:0] f);
		return (f[3] ? NIRSC_MA_W3 : 7'h00) + (f[2] ? NIRSC_MA_W2 : 7'h00) + (f[1] ? NIRSC_MA_W1 : 7'h00)
			+ (f[0] ? NIRSC_MA_W0 : 7'h00);
	endfunction : ma
	function automatic logic [15:0] span(input int len, input int base);
		return (len >= base && len <= base + 3) ? 16'h0001 : 16'h0000;
	endfunction : span
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge clock);
		errors++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		adc = 16'h0000;
		repeat (8) @(negedge clock);
		rst = 1'b0;
		host_u.tick(6);
		host_u.rd(NIRSC_REG_CTRL, v);
		// monitor bit reads 1 while reset and standby are set
		chk(v, {NIRSC_CTRL_RESET_VAL | 8'h20, 8'h00});
		chk({12'h000, conv_reset, conv_standby, led_reset, led_standby}, 16'h000F);
		host_u.rd(NIRSC_REG_LED_ONE, v);
		chk(v, {NIRSC_LED_ONE_RESET_VAL, NIRSC_LED_TWO_RESET_VAL});
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			d1 = (i == 0) ? 8'hFF : 8'($random(seed));
			d2 = (i == 0) ? 8'h0F : 8'($random(seed));
			host_u.wr(NIRSC_REG_LED_ONE, d1);
			host_u.wr(NIRSC_REG_LED_TWO, d2);
			chk({12'h000, led_reset, led_standby, led_dc_mode, led_tenth}, {12'h000, d1[7:4]});
			chk({2'b00, e1, e2}, {2'b00, ma(d2[7:4]), ma(d1[3:0])});
			chk({9'h000, e3}, {9'h000, ma(d2[3:0])});
			host_u.rd(NIRSC_REG_LED_ONE, v);
			chk(v, {d1, d2});
		end
		$display("emitter test done");
		host_u.addr = 7'h2B;
		host_u.wr(NIRSC_REG_LED_ONE, 8'h00);
		chk({15'h0000, host_u.nack}, 16'h0001);
		host_u.addr = NIRSC_DEV_ADDR;
		host_u.rd(NIRSC_REG_LED_ONE, v);
		chk(v, {d1, d2});
		host_u.wr(NIRSC_REG_CTRL, 8'h88);
		chk({14'h0000, conv_low_gain, conv_reset}, 16'h0003);
		host_u.wr(NIRSC_REG_CTRL, 8'h80);
		chk({14'h0000, conv_low_gain, conv_reset}, 16'h0001);
		$display("address and gain test done");
		// the two long codes would outrun the cycle budget
		for (int c = 0; c < 2; c++) begin
			t = c ? NIRSC_TINT_1_CYC : NIRSC_TINT_0_CYC;
			adc = 16'($random(seed));
			host_u.wr(NIRSC_REG_CTRL, 8'h80 | 8'(c));
			host_u.wr(NIRSC_REG_CTRL, 8'h20 | 8'(c));
			host_u.tick(2 * t + 300);
			chk(span(last_len, t), 16'h0001);
			host_u.rd(NIRSC_REG_CTRL, v);
			chk(v, {6'h00, 2'(c), 8'h00});
			host_u.rd(8'h05, v);
			chk(v, adc);
			adc = 16'($random(seed));
			host_u.tick(2 * t + 300);
			host_u.rd(8'h05, v);
			chk(v, adc);
		end
		$display("fixed mode test done");
		host_u.wr(NIRSC_REG_CTRL, 8'h90);
		host_u.rd(NIRSC_REG_DATA_HI, v);
		chk(v, 16'h0000);
		host_u.wr(NIRSC_REG_CTRL, 8'h80);
		host_u.rd(NIRSC_REG_DATA_HI, v);
		chk(v, 16'h0000);
		$display("clear test done");
		host_u.wr(NIRSC_REG_MAN_HI, 8'h00);
		host_u.wr(NIRSC_REG_MAN_LO, 8'h02);
		adc = 16'($random(seed));
		ev = adc;
		host_u.wr(NIRSC_REG_CTRL, 8'h84);
		host_u.wr(NIRSC_REG_CTRL, 8'h04);
		host_u.tick(1000);
		chk(span(last_len, 2 * NIRSC_TINT_0_CYC), 16'h0001);
		host_u.rd(NIRSC_REG_CTRL, v);
		chk(v, 16'h6400);
		adc = 16'($random(seed));
		host_u.tick(1000);
		host_u.rd(8'h05, v);
		chk(v, ev);
		$display("manual mode test done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
